/* File: logic/rstc_pkg.sv */
// Purpose: Shared constants and types for the reset input handling block
// Assumes: 20 MHz ref_clk, Avalon-MM register slave with byte addresses
// Notes: Identification codes below are arbitrary values
package rstc_pkg;
  localparam int CLK_MHZ = 20;
  localparam int MIN_PULSE_US = 92;
  localparam int MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
  localparam int PULSE_CNT_W = 11;
  localparam logic [PULSE_CNT_W-1:0] MIN_PULSE_CNT = PULSE_CNT_W'(MIN_PULSE_CYC);

  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h04;
  localparam logic [4:0] OFS_FETCH = 5'h08;
  localparam logic [4:0] OFS_INSTR = 5'h0c;
  localparam logic [4:0] OFS_PSR = 5'h10;
  localparam logic [4:0] OFS_SCRATCH = 5'h14;

  localparam int CTL_REMAP_BIT = 0;
  localparam int CTL_DEBUG_BIT = 1;
  localparam int CTL_TAP_RUN_BIT = 2;
  localparam int CTL_CLR_SHORT_BIT = 3;

  localparam logic [31:0] FETCH_RST = 32'h0000_0000;
  localparam logic [31:0] FETCH_STEP = 32'h0000_0004;
  // Arbitrary value
  localparam logic [31:0] PSR_RST = 32'h0000_001f;
  // Arbitrary instruction codes
  localparam logic [3:0] IDCODE_INSTR = 4'h1;
  localparam logic [3:0] IDENT_INSTR_ALT = 4'he;

  localparam logic [1:0] AREA0_ROM = 2'h0;
  localparam logic [1:0] AREA0_EXT_CS0 = 2'h1;
  localparam logic [1:0] AREA0_SRAM = 2'h2;

  typedef enum logic [1:0] {
    RSTC_TAP_RESET = 2'b01,
    RSTC_TAP_IDLE = 2'b10
  } rstc_tap_state_t;

  typedef struct packed {
    logic short_pulse;
    logic remap;
    logic tap_in_reset;
    logic debug;
    logic scan_mode;
    logic boot_sel;
  } rstc_status_t;
endpackage : rstc_pkg

/* File: logic/rstc_sync.sv */
// Purpose: Reset synchroniser, asynchronous assert and clocked release
// Assumes: arst_low is the raw active low reset pin
// Notes: Two stages; only the second stage is seen outside
`timescale 1ns/1ps
module rstc_sync
  import rstc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_low,
  output logic sync_active
);
  logic [1:0] stage_q;
  logic [1:0] stage_d;

  always_comb begin
    stage_d = {stage_q[0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge arst_low) begin
    if (!arst_low) begin
      stage_q <= 2'b00;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sync_active = ~stage_q[1];
endmodule : rstc_sync

/* File: logic/rstc_core.sv */
// Purpose: System and test-port reset inputs, boot strap capture, area 0 map
// Assumes: Pin inputs synchronous to ref_clk; rst resets the bus slave
// Notes: Core and TAP state are reduced models seen through registers
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rstc_core
  import rstc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic system_reset_low,
  input wire logic test_port_reset_low,
  input wire logic boot_select_pin,
  input wire logic scan_mode_select_pin,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic core_reset_active,
  output logic core_abort,
  output logic [31:0] fetch_addr,
  output logic [1:0] area0_select,
  output logic boot_sel,
  output logic scan_mode,
  output logic debug_state,
  output logic [3:0] bscan_instr,
  output logic [3:0] ice_instr,
  output logic bscan_in_reset
);
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic boot_q, boot_d, scan_q, scan_d;
  logic [31:0] fetch_q, fetch_d, psr_q, psr_d, scratch_q, scratch_d;
  logic remap_q, remap_d;
  logic debug_q, debug_d;
  logic [3:0] bir_q, bir_d, iir_q, iir_d;
  rstc_tap_state_t tap_q, tap_d;
  logic [1:0] area0_q, area0_d;
  logic [PULSE_CNT_W-1:0] low_cnt_q, low_cnt_d;
  logic short_q, short_d, pin_prev_q;
  logic bscan_rst_low, ice_rst_low;
  logic req, wr_en;
  rstc_status_t status;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  rstc_sync u_sync (
    .ref_clk(ref_clk),
    .arst_low(system_reset_low),
    .sync_active(core_reset_active)
  );

  // Abort is a pure gate so it acts before any clock edge
  assign core_abort = ~system_reset_low;

  // Gated resets: only the controller picked by the strap sees the pin.
  // A strap change is only possible inside the internal reset, so no glitch in use.
  // System reset clears both, so the unpicked controller never starts undefined.
  assign bscan_rst_low = system_reset_low & (test_port_reset_low | ~scan_q);
  assign ice_rst_low = system_reset_low & (test_port_reset_low | scan_q);

  // Bus slave: one wait cycle, then answer
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en = avs_write & ack_q;

  always_comb begin
    status = '{short_pulse: short_q, remap: remap_q, tap_in_reset: (tap_q == RSTC_TAP_RESET),
               debug: debug_q, scan_mode: scan_q, boot_sel: boot_q};
    ack_d = rst ? 1'b0 : (req & ~ack_q);
    rdata_d = rdata_q;
    if (rst) begin
      rdata_d = 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      if (hit(avs_address, OFS_STATUS)) begin
        rdata_d = {26'h000_0000, status};
      end else if (hit(avs_address, OFS_CONTROL)) begin
        rdata_d = {31'h0000_0000, remap_q};
      end else if (hit(avs_address, OFS_FETCH)) begin
        rdata_d = fetch_q;
      end else if (hit(avs_address, OFS_INSTR)) begin
        rdata_d = {24'h00_0000, iir_q, bir_q};
      end else if (hit(avs_address, OFS_PSR)) begin
        rdata_d = psr_q;
      end else if (hit(avs_address, OFS_SCRATCH)) begin
        rdata_d = scratch_q;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    ack_q <= ack_d;
    rdata_q <= rdata_d;
  end

  // Straps follow the pins for as long as the internal reset is active
  always_comb begin
    boot_d = core_reset_active ? boot_select_pin : boot_q;
    scan_d = core_reset_active ? scan_mode_select_pin : scan_q;
  end

  always_ff @(posedge ref_clk) begin
    boot_q <= boot_d;
    scan_q <= scan_d;
  end

  // Core model: fetch address, status register, remap
  always_comb begin
    fetch_d = fetch_q;
    psr_d = psr_q;
    remap_d = remap_q;
    if (core_reset_active) begin
      fetch_d = FETCH_RST;
    end else if (!debug_q) begin
      fetch_d = fetch_q + FETCH_STEP;
    end
    if (wr_en && hit(avs_address, OFS_PSR)) begin
      psr_d = avs_writedata;
    end
    if (wr_en && hit(avs_address, OFS_CONTROL)) begin
      remap_d = avs_writedata[CTL_REMAP_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge system_reset_low) begin
    if (!system_reset_low) begin
      fetch_q <= FETCH_RST;
      psr_q <= PSR_RST;
      remap_q <= 1'b0;
    end else begin
      fetch_q <= fetch_d;
      psr_q <= psr_d;
      remap_q <= remap_d;
    end
  end

  // General register: no reset at all, by design
  always_comb begin
    scratch_d = (wr_en && hit(avs_address, OFS_SCRATCH)) ? avs_writedata : scratch_q;
  end

  always_ff @(posedge ref_clk) begin
    scratch_q <= scratch_d;
  end

  // Boundary-scan controller, no test clock needed for its reset
  always_comb begin
    tap_d = tap_q;
    bir_d = bir_q;
    if (wr_en && hit(avs_address, OFS_CONTROL) && avs_writedata[CTL_TAP_RUN_BIT]) begin
      tap_d = RSTC_TAP_IDLE;
    end
    if (wr_en && hit(avs_address, OFS_INSTR)) begin
      bir_d = avs_writedata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge bscan_rst_low) begin
    if (!bscan_rst_low) begin
      tap_q <= RSTC_TAP_RESET;
      bir_q <= IDCODE_INSTR;
    end else begin
      tap_q <= tap_d;
      bir_q <= bir_d;
    end
  end

  // Emulator controller; debug holds the fetch address, the PSR is never touched
  always_comb begin
    debug_d = debug_q;
    iir_d = iir_q;
    if (wr_en && hit(avs_address, OFS_CONTROL) && avs_writedata[CTL_DEBUG_BIT]) begin
      debug_d = 1'b1;
    end
    if (wr_en && hit(avs_address, OFS_INSTR)) begin
      iir_d = avs_writedata[7:4];
    end
  end

  always_ff @(posedge ref_clk or negedge ice_rst_low) begin
    if (!ice_rst_low) begin
      debug_q <= 1'b0;
      iir_q <= IDENT_INSTR_ALT;
    end else begin
      debug_q <= debug_d;
      iir_q <= iir_d;
    end
  end

  // Area 0 decode
  always_comb begin
    if (remap_q) begin
      area0_d = AREA0_SRAM;
    end else if (boot_q) begin
      area0_d = AREA0_ROM;
    end else begin
      area0_d = AREA0_EXT_CS0;
    end
  end

  always_ff @(posedge ref_clk) begin
    area0_q <= area0_d;
  end

  // Short pulse watch: flags a user reset held under the minimum width.
  // Cannot tell power-up from user resets, so software decides what it means.
  always_comb begin
    low_cnt_d = low_cnt_q;
    short_d = short_q;
    if (rst) begin
      low_cnt_d = '0;
      short_d = 1'b0;
    end else begin
      if (!system_reset_low) begin
        low_cnt_d = (low_cnt_q == MIN_PULSE_CNT) ? low_cnt_q : low_cnt_q + 1'b1;
      end else begin
        low_cnt_d = '0;
      end
      if (wr_en && hit(avs_address, OFS_CONTROL) && avs_writedata[CTL_CLR_SHORT_BIT]) begin
        short_d = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (system_reset_low && !pin_prev_q && (low_cnt_q < MIN_PULSE_CNT)) begin
        short_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    low_cnt_q <= low_cnt_d;
    short_q <= short_d;
    pin_prev_q <= rst ? 1'b1 : system_reset_low;
  end

  assign avs_readdata = rdata_q;
  assign fetch_addr = fetch_q;
  assign area0_select = area0_q;
  assign boot_sel = boot_q;
  assign scan_mode = scan_q;
  assign debug_state = debug_q;
  assign bscan_instr = bir_q;
  assign ice_instr = iir_q;
  assign bscan_in_reset = (tap_q == RSTC_TAP_RESET);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_release;
    $rose(system_reset_low) ##1 system_reset_low ##1 system_reset_low;
  endsequence

  property p_assert_now;
    !system_reset_low |-> core_reset_active && core_abort && fetch_q == FETCH_RST;
  endproperty
  a_assert_now: assert property (p_assert_now) else $error("reset not immediate");

  property p_release_held;
    $rose(system_reset_low) |-> core_reset_active ##1 (core_reset_active || !system_reset_low);
  endproperty
  a_release_held: assert property (p_release_held) else $error("early release");

  property p_release_done;
    s_release |-> !core_reset_active;
  endproperty
  a_release_done: assert property (p_release_done) else $error("late release");

  property p_boot_capture;
    core_reset_active |=> boot_q == $past(boot_select_pin) && scan_q == $past(scan_mode_select_pin);
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("strap missed");

  property p_area0;
    !remap_q |=> area0_q == ($past(boot_q) ? AREA0_ROM : AREA0_EXT_CS0);
  endproperty
  a_area0: assert property (p_area0) else $error("area0 wrong");

  property p_bscan_reset;
    !test_port_reset_low && scan_q |-> bscan_in_reset && bir_q == IDCODE_INSTR;
  endproperty
  a_bscan_reset: assert property (p_bscan_reset) else $error("scan tap not reset");

  property p_ice_reset;
    !test_port_reset_low && !scan_q |-> !debug_q && iir_q == IDENT_INSTR_ALT;
  endproperty
  a_ice_reset: assert property (p_ice_reset) else $error("ice not reset");

  property p_run_on;
    !test_port_reset_low && !core_reset_active && !debug_q && system_reset_low
      |=> fetch_q == $past(fetch_q) + FETCH_STEP || !system_reset_low;
  endproperty
  a_run_on: assert property (p_run_on) else $error("execution disturbed");

  property p_first_fetch;
    $fell(core_reset_active) |-> fetch_q == FETCH_RST;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch not zero");

  property p_defaults;
    !system_reset_low |-> !remap_q && psr_q == PSR_RST;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults lost");
endmodule : rstc_core

/* File: test/rstc_supervisor.sv */
// Purpose: Reset supervisor and debug probe model driving the reset pins
// Assumes: Pins move by non-blocking assignment just after a rising edge
// Notes: Straps swing after release so a late capture shows up
`timescale 1ns/1ps
module rstc_supervisor
  import rstc_pkg::*;
#(
  parameter int TAP_MIN_CYC = 4
)
(
  input wire logic ref_clk,
  output logic system_reset_low,
  output logic test_port_reset_low,
  output logic boot_select_pin,
  output logic scan_mode_select_pin
);
  // Cold start: both resets low from time zero
  initial begin
    system_reset_low = 1'b0;
    test_port_reset_low = 1'b0;
    boot_select_pin = 1'b1;
    scan_mode_select_pin = 1'b1;
  end

  task automatic sys_assert(input logic boot, input logic scan);
    @(posedge ref_clk);
    system_reset_low <= 1'b0;
    boot_select_pin <= boot;
    scan_mode_select_pin <= scan;
  endtask : sys_assert

  // Hold time is the caller's; short holds only when a scenario asks
  task automatic sys_release(input int cyc);
    repeat (cyc) @(posedge ref_clk);
    system_reset_low <= 1'b1;
    fork
      begin
        repeat (4) @(posedge ref_clk);
        boot_select_pin <= ~boot_select_pin;
        scan_mode_select_pin <= ~scan_mode_select_pin;
      end
    join_none
  endtask : sys_release

  // No test clock exists in this model
  task automatic tap_assert();
    @(posedge ref_clk);
    test_port_reset_low <= 1'b0;
  endtask : tap_assert

  // Never shorter than the minimum width
  task automatic tap_release(input int cyc);
    repeat ((cyc < TAP_MIN_CYC) ? TAP_MIN_CYC : cyc) @(posedge ref_clk);
    test_port_reset_low <= 1'b1;
  endtask : tap_release
endmodule : rstc_supervisor

/* File: test/tb_system_and_tap_reset_inputs.sv */
// Purpose: Self-checking bench for the reset input handling block
// Assumes: Reset pins and straps come from the supervisor model
// Notes: Reads queue their expectation; a monitor compares on completion
`timescale 1ns/1ps
module tb_system_and_tap_reset_inputs import rstc_pkg::*;;
  localparam int PWR_CYC = 2400;
  localparam int LIMIT = 20000;
  logic ref_clk, rst, avs_read, avs_write;
  logic system_reset_low, test_port_reset_low, boot_select_pin, scan_mode_select_pin;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, fetch_addr, d, f;
  logic avs_waitrequest, core_reset_active, core_abort, boot_sel, scan_mode;
  logic debug_state, bscan_in_reset;
  logic [1:0] area0_select;
  logic [3:0] bscan_instr, ice_instr;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000_4724;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  rstc_core dut_u (.ref_clk(ref_clk), .rst(rst), .system_reset_low(system_reset_low),
    .test_port_reset_low(test_port_reset_low), .boot_select_pin(boot_select_pin),
    .scan_mode_select_pin(scan_mode_select_pin), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_reset_active(core_reset_active), .core_abort(core_abort),
    .fetch_addr(fetch_addr), .area0_select(area0_select), .boot_sel(boot_sel),
    .scan_mode(scan_mode), .debug_state(debug_state), .bscan_instr(bscan_instr),
    .ice_instr(ice_instr), .bscan_in_reset(bscan_in_reset));

  rstc_supervisor sup_u (.ref_clk(ref_clk), .system_reset_low(system_reset_low),
    .test_port_reset_low(test_port_reset_low), .boot_select_pin(boot_select_pin),
    .scan_mode_select_pin(scan_mode_select_pin));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Waits without a count of its own; the cycle ceiling cuts a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check(avs_readdata, exp_q.pop_front());
    end
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(core_abort, 32'h1);
    check(core_reset_active, 32'h1);
    check(fetch_addr, FETCH_RST);
    sup_u.tap_release(4);
    sup_u.sys_release(PWR_CYC);
    tick(1);
    check(core_reset_active, 32'h1);
    tick(1);
    check(core_reset_active, 32'h0);
    check(core_abort, 32'h0);
    check(fetch_addr, FETCH_RST);
    tick(1);
    check(fetch_addr, FETCH_STEP);
    tick(4);
    check(boot_sel, 32'h1);
    check(area0_select, AREA0_ROM);
    rd(OFS_STATUS, 32'h0000_000b);
    rd(OFS_PSR, PSR_RST);
    rd(OFS_INSTR, {24'h0, IDENT_INSTR_ALT, IDCODE_INSTR});
    bus(1'b1, 5'h1c, rnd());
    rd(5'h1c, 32'h0000_0000);
    repeat (3) begin
      d = rnd();
      bus(1'b1, OFS_PSR, d);
      rd(OFS_PSR, d);
      bus(1'b1, OFS_SCRATCH, ~d);
      rd(OFS_SCRATCH, ~d);
    end
    // Boundary-scan mode: only the scan TAP is hit, fetch keeps running
    d = rnd();
    bus(1'b1, OFS_INSTR, d);
    bus(1'b1, OFS_CONTROL, 32'h0000_0005);
    rd(OFS_CONTROL, 32'h0000_0001);
    tick(1);
    check(area0_select, AREA0_SRAM);
    check(bscan_in_reset, 32'h0);
    f = fetch_addr;
    sup_u.tap_assert();
    #1;
    check(bscan_in_reset, 32'h1);
    check(bscan_instr, IDCODE_INSTR);
    check(ice_instr, d[7:4]);
    sup_u.tap_release(4);
    #1;
    check(fetch_addr, f + 32'd20);
    // Manual reset with both straps low, held just over the minimum
    sup_u.sys_assert(1'b0, 1'b0);
    #1;
    check(core_abort, 32'h1);
    check(fetch_addr, FETCH_RST);
    sup_u.sys_release(MIN_PULSE_CYC + 2);
    tick(6);
    check(boot_sel, 32'h0);
    check(scan_mode, 32'h0);
    check(area0_select, AREA0_EXT_CS0);
    rd(OFS_PSR, PSR_RST);
    // Emulator mode: test reset leaves debug and picks the alternate code
    d = rnd();
    bus(1'b1, OFS_INSTR, d);
    bus(1'b1, OFS_CONTROL, 32'h0000_0002);
    tick(1);
    check(debug_state, 32'h1);
    sup_u.tap_assert();
    #1;
    check(debug_state, 32'h0);
    check(ice_instr, IDENT_INSTR_ALT);
    check(bscan_instr, d[3:0]);
    sup_u.tap_release(4);
    // Deliberately short pulse raises the flag; status is read-only
    sup_u.sys_assert(1'b1, 1'b1);
    sup_u.sys_release(10);
    tick(4);
    bus(1'b1, OFS_CONTROL, 32'h0000_0004);
    bus(1'b1, OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, 32'h0000_0023);
    bus(1'b1, OFS_CONTROL, 32'h0000_0008);
    rd(OFS_STATUS, 32'h0000_0003);
    tick(2);
    final_report();
  end
endmodule : tb_system_and_tap_reset_inputs
